// [design/limp_cfg_pkg.sv]
// Package: register map, field layout, reset values and timer table of the limp-home bank
package limp_cfg_pkg;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] ADDR_MAIN_TIMER  = 8'h20;
  localparam logic [7:0] ADDR_ENABLE_A    = 8'h21;
  localparam logic [7:0] ADDR_ENABLE_B    = 8'h22;
  localparam logic [7:0] ADDR_LATCH       = 8'h23;
  localparam logic [7:0] ADDR_OV_THRESH   = 8'h24;
  localparam logic [7:0] ADDR_TRIM        = 8'h25;
  localparam logic [7:0] ADDR_SOFT_RESET  = 8'h26;

  // ***************************************************************
  // Reset values, writable masks and command key
  // ***************************************************************
  localparam logic [7:0] RST_MAIN_TIMER   = 8'h99;
  localparam logic [7:0] RST_ENABLE_A     = 8'h3c;
  localparam logic [7:0] RST_ENABLE_B     = 8'h0f;
  localparam logic [7:0] RST_LATCH        = 8'h00;
  localparam logic [7:0] RST_OV_THRESH    = 8'h22;
  localparam logic [7:0] RST_TRIM         = 8'h00;
  localparam logic [7:0] MASK_ENABLE_B    = 8'h3f;   // Two top bits reserved
  localparam logic [7:0] MASK_OV_THRESH   = 8'h77;   // Bits 7 and 3 reserved
  localparam logic [7:0] SOFT_RESET_KEY   = 8'hc3;
  localparam logic [7:0] READ_ZERO        = 8'h00;
  localparam logic       PC_POWER_ON      = 1'b1;

  // ***************************************************************
  // Field positions (channel 2 sits one bit, or one stride, above channel 1)
  // ***************************************************************
  localparam int POS_EN_UV   = 0;
  localparam int POS_EN_OV   = 2;
  localparam int POS_EN_FBO  = 4;
  localparam int POS_EN_RAMP = 6;
  localparam int POS_EN_ISO  = 0;
  localparam int POS_EN_CURRENT_LIMIT = 2;
  localparam int POS_EN_OC   = 4;
  localparam int POS_LT_UV   = 0;
  localparam int POS_LT_OV   = 2;
  localparam int POS_LT_OC   = 4;
  localparam int POS_LT_CURRENT_LIMIT = 6;
  localparam int FIELD_STRIDE = 4;   // Timer code, threshold code and trim nibble stride
  localparam int TIMER_CODE_W = 4;
  localparam int OV_CODE_W    = 3;
  localparam int TRIM_W       = 3;
  localparam int POS_FORCE_OFF = 0;
  localparam int POS_TRIM      = 1;

  // ***************************************************************
  // Fault vector layout inside a channel
  // ***************************************************************
  localparam int NUM_FAULTS = 6;
  localparam int F_UV   = 0;
  localparam int F_OV   = 1;
  localparam int F_FBO  = 2;
  localparam int F_OC   = 3;
  localparam int F_CURRENT_LIMIT = 4;
  localparam int F_ISO  = 5;

  // ***************************************************************
  // Main fault timer terminal counts, indexed by the 4-bit code
  // ***************************************************************
  localparam int TIMER_W = 14;
  localparam logic [TIMER_W-1:0] TIMER_OFF = 14'h0000;
  localparam logic [15:0][TIMER_W-1:0] TIMER_LIMIT = {
    14'h3fff, 14'h36b0, 14'h2ee0, 14'h2710,   // 16383, 14000, 12000, 10000
    14'h1f40, 14'h1b58, 14'h1770, 14'h1388,   // 8000, 7000, 6000, 5000
    14'h0fa0, 14'h0dac, 14'h0bb8, 14'h09c4,   // 4000, 3500, 3000, 2500
    14'h07d0, 14'h05dc, 14'h03e8, 14'h0000    // 2000, 1500, 1000, disabled
  };

endpackage : limp_cfg_pkg

// [design/main_fault_timer.sv]
// Per-channel main fault timer: 14-bit counter on channel clock ticks
module main_fault_timer #(
  parameter int WIDTH = limp_cfg_pkg::TIMER_W
) (
  input  wire logic       clk,     // System clock
  input  wire logic       rst_n,   // Async reset, active low
  input  wire logic       tick,    // One-cycle channel clock edge
  input  wire logic       run,     // Timed fault present
  input  wire logic [3:0] code,    // Terminal count code
  output logic            expired  // Terminal count reached
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             expired;
  } timer_state_t;

  timer_state_t st_q;
  timer_state_t st_d;
  logic [WIDTH-1:0] limit;

  assign limit   = WIDTH'(limp_cfg_pkg::TIMER_LIMIT[code]);
  assign expired = st_q.expired;

  // Count while a timed fault lasts; code zero never expires
  always_comb begin
    st_d = st_q;
    if (!run || limit == WIDTH'(limp_cfg_pkg::TIMER_OFF)) begin
      st_d.count   = '0;
      st_d.expired = 1'b0;
    end else if (st_q.count == limit) begin
      st_d.expired = 1'b1;
    end else if (tick) begin
      st_d.count = st_q.count + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : main_fault_timer

// [design/channel_fault_guard.sv]
// Per-channel fault qualification and latched shutdown flag
module channel_fault_guard (
  input  wire logic       clk,          // System clock
  input  wire logic       rst_n,        // Async reset, active low
  input  wire logic       apply,        // Limp-home settings in force
  input  wire logic       soft_start,   // Channel before or in its ramp
  input  wire logic       cv_mode,      // Constant-voltage mode
  input  wire logic       ramp_enable,  // Faults live during ramp
  input  wire logic [5:0] enables,      // Per-fault enables
  input  wire logic [5:0] latches,      // Per-fault latch selects
  input  wire logic [5:0] events,       // Raw fault levels
  input  wire logic       restart,      // Host wrote 1 to channel enable
  output logic            fault_any,    // Any fault that drives the flag
  output logic            timer_run,    // Non-latched fault running timer
  output logic            latched_off   // Latched shutdown in force
);

  typedef struct packed {
    logic latched;
  } guard_state_t;

  guard_state_t st_q;
  guard_state_t st_d;
  logic [5:0]   active;

  // Qualify raw faults; a disabled fault never reaches the flag
  always_comb begin
    active = events & enables & {limp_cfg_pkg::NUM_FAULTS{apply}};
    if (soft_start && !ramp_enable) begin
      active[limp_cfg_pkg::F_UV] = 1'b0;
      if (cv_mode) begin
        active[limp_cfg_pkg::F_CURRENT_LIMIT] = 1'b0;
      end
    end
    // With ramp_enable high every enabled fault passes untouched
  end

  assign timer_run   = |(active & ~latches);
  assign fault_any   = (|active) | st_q.latched;
  assign latched_off = st_q.latched;

  // A new latched hit beats a restart arriving in the same cycle
  always_comb begin
    st_d = st_q;
    st_d.latched = (|(active & latches)) | (st_q.latched & ~restart);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : channel_fault_guard

// [design/limp_home_fault_config_regs.sv]
// Limp-home fault configuration bank with fault timers and channel shutdown

// Notes on behaviour
// - Per-channel 14-bit timer counts channel clock
// - Timer code picks terminal count; zero disables
// - Dual phase: timer 1 only, acts both
// - Fault settings apply only while pin high; set latches outlast the pin
// - Disabled faults never affect the fault flag
// - Ramp enable low masks UV, CV CURRENT_LIMIT
// - Ramp enable high keeps enabled faults live
// - Feedback open enable per channel, no status
// - OV/UV enables; channel 2 off in dual
// - Second enable: OC, CURRENT_LIMIT, sense open; reserved
// - Latched fault holds channel off until restart
// - Latch bits make faults latched; default zero
// - Three-bit code sets overvoltage threshold step
// - Dual phase uses channel 1 fields, except trim and force-off
// - Three trim bits per channel for sense
// - Force-off bit turns its channel off
// - Key write restores all registers to defaults
// - Soft reset register reads as zero
// - Soft reset spares the persistent config bit
module limp_home_fault_config_regs (
  input  wire logic       clk,                       // System clock, 250 MHz
  input  wire logic       rst_n,                     // Async power-on reset, active low
  input  wire logic       reg_wr_en,                 // Register write strobe
  input  wire logic       reg_rd_en,                 // Register read strobe
  input  wire logic [7:0] reg_addr,                  // Register address
  input  wire logic [7:0] reg_wdata,                 // Write data
  output logic      [7:0] reg_rdata,                 // Read data
  output logic            reg_rd_valid,              // Read data valid pulse
  input  wire logic       persistent_config_wr,      // Write strobe for persistent bit
  input  wire logic       persistent_config_wdata,   // Value for persistent bit
  output logic            persistent_config_bit,     // Persistent config bit
  input  wire logic       limp_home_pin,             // Limp-home pin level
  input  wire logic       dual_phase_select,         // Dual-phase selection
  input  wire logic       cv_mode,                   // Constant-voltage mode
  input  wire logic [1:0] channel_clock,             // Channel clocks, sampled
  input  wire logic [1:0] soft_start_active,         // Channel in soft-start
  input  wire logic [1:0] channel_restart,           // Enable bit written 1, pulse
  input  wire logic [5:0] fault_event_ch1,           // Raw faults, channel 1
  input  wire logic [5:0] fault_event_ch2,           // Raw faults, channel 2
  output logic      [1:0] fault_pin_oe,              // Drive fault pin low when high
  output logic      [1:0] channel_off,               // Channel shutdown request
  output logic      [5:0] ov_threshold_code,         // Effective codes, ch2 in [5:3]
  output logic      [5:0] sense_offset_trim_bits     // Trim, ch2 in [5:3]
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [7:0] main_timer;
    logic [7:0] enable_a;
    logic [7:0] enable_b;
    logic [7:0] latch;
    logic [7:0] ov_thresh;
    logic [7:0] trim;
    logic       pc_bit;
    logic [1:0] clk_prev;
    logic [7:0] rdata;
    logic       rd_valid;
    logic [1:0] fault_oe;
    logic [1:0] chan_off;
    logic [5:0] ov_out;
    logic [5:0] trim_out;
  } regs_state_t;

  regs_state_t st_q;
  regs_state_t st_d;

  logic [1:0]      tick;
  logic [1:0][5:0] events;
  logic [1:0][5:0] ch_enables;
  logic [1:0][5:0] ch_latches;
  logic [1:0][3:0] ch_code;
  logic [1:0][2:0] ch_ov_code;
  logic [1:0]      ch_ramp_en;
  logic [1:0]      ch_fault_any;
  logic [1:0]      ch_timer_run;
  logic [1:0]      ch_latched_off;
  logic [1:0]      tmr_run;
  logic [1:0]      tmr_expired;
  logic [1:0]      ch_expired;

  // Inputs are synchronous, so a plain previous-sample edge detect is safe
  assign tick      = channel_clock & ~st_q.clk_prev;
  assign events[0] = fault_event_ch1;
  assign events[1] = fault_event_ch2;

  // ***************************************************************
  // Per-channel configuration selection and fault engines
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic sel;      // Field index used by this channel
      logic ovuv_ok;  // Channel 2 OV/UV are dropped in dual phase
      assign sel     = (g == 1) && !dual_phase_select;
      assign ovuv_ok = !((g == 1) && dual_phase_select);

      assign ch_code[g] =
        st_q.main_timer[limp_cfg_pkg::FIELD_STRIDE*sel +: limp_cfg_pkg::TIMER_CODE_W];
      assign ch_ov_code[g] =
        st_q.ov_thresh[limp_cfg_pkg::FIELD_STRIDE*sel +: limp_cfg_pkg::OV_CODE_W];
      assign ch_ramp_en[g] = st_q.enable_a[limp_cfg_pkg::POS_EN_RAMP + sel];

      // Enable vector in fault-index order
      assign ch_enables[g] = {
        st_q.enable_b[limp_cfg_pkg::POS_EN_ISO + sel],
        st_q.enable_b[limp_cfg_pkg::POS_EN_CURRENT_LIMIT + sel],
        st_q.enable_b[limp_cfg_pkg::POS_EN_OC + sel],
        st_q.enable_a[limp_cfg_pkg::POS_EN_FBO + sel],
        st_q.enable_a[limp_cfg_pkg::POS_EN_OV + sel] & ovuv_ok,
        st_q.enable_a[limp_cfg_pkg::POS_EN_UV + sel] & ovuv_ok
      };

      // Feedback-open and sense-open can never be latched
      assign ch_latches[g] = {
        1'b0,
        st_q.latch[limp_cfg_pkg::POS_LT_CURRENT_LIMIT + sel],
        st_q.latch[limp_cfg_pkg::POS_LT_OC + sel],
        1'b0,
        st_q.latch[limp_cfg_pkg::POS_LT_OV + sel],
        st_q.latch[limp_cfg_pkg::POS_LT_UV + sel]
      };

      channel_fault_guard u_guard (
        .clk         (clk),
        .rst_n       (rst_n),
        .apply       (limp_home_pin),
        .soft_start  (soft_start_active[g]),
        .cv_mode     (cv_mode),
        .ramp_enable (ch_ramp_en[g]),
        .enables     (ch_enables[g]),
        .latches     (ch_latches[g]),
        .events      (events[g]),
        .restart     (channel_restart[g]),
        .fault_any   (ch_fault_any[g]),
        .timer_run   (ch_timer_run[g]),
        .latched_off (ch_latched_off[g])
      );

      main_fault_timer #(
        .WIDTH (limp_cfg_pkg::TIMER_W)
      ) u_timer (
        .clk     (clk),
        .rst_n   (rst_n),
        .tick    (tick[g]),
        .run     (tmr_run[g]),
        .code    (ch_code[g]),
        .expired (tmr_expired[g])
      );

      // In dual phase timer 1 alone decides expiry for both channels
      assign ch_expired[g] = dual_phase_select ? tmr_expired[0] : tmr_expired[g];
    end
  endgenerate

  // Timer 1 collects both channels in dual phase; timer 2 is held idle
  assign tmr_run[0] = ch_timer_run[0] | (dual_phase_select & ch_timer_run[1]);
  assign tmr_run[1] = ch_timer_run[1] & ~dual_phase_select;

  // ***************************************************************
  // Register access, soft reset and output registers
  // ***************************************************************
  always_comb begin
    st_d          = st_q;
    st_d.clk_prev = channel_clock;
    st_d.rd_valid = reg_rd_en;
    st_d.rdata    = limp_cfg_pkg::READ_ZERO;

    // Persistent bit is outside the soft reset domain on purpose
    if (persistent_config_wr) begin
      st_d.pc_bit = persistent_config_wdata;
    end

    if (reg_wr_en) begin
      unique case (reg_addr)
        limp_cfg_pkg::ADDR_MAIN_TIMER: st_d.main_timer = reg_wdata;
        limp_cfg_pkg::ADDR_ENABLE_A:   st_d.enable_a   = reg_wdata;
        limp_cfg_pkg::ADDR_ENABLE_B:   st_d.enable_b   = reg_wdata & limp_cfg_pkg::MASK_ENABLE_B;
        limp_cfg_pkg::ADDR_LATCH:      st_d.latch      = reg_wdata;
        limp_cfg_pkg::ADDR_OV_THRESH:  st_d.ov_thresh  = reg_wdata & limp_cfg_pkg::MASK_OV_THRESH;
        limp_cfg_pkg::ADDR_TRIM:       st_d.trim       = reg_wdata;
        limp_cfg_pkg::ADDR_SOFT_RESET: begin
          // Only the key acts; any other value leaves every register alone
          if (reg_wdata == limp_cfg_pkg::SOFT_RESET_KEY) begin
            st_d.main_timer = limp_cfg_pkg::RST_MAIN_TIMER;
            st_d.enable_a   = limp_cfg_pkg::RST_ENABLE_A;
            st_d.enable_b   = limp_cfg_pkg::RST_ENABLE_B;
            st_d.latch      = limp_cfg_pkg::RST_LATCH;
            st_d.ov_thresh  = limp_cfg_pkg::RST_OV_THRESH;
            st_d.trim       = limp_cfg_pkg::RST_TRIM;
          end
        end
        default: ;                                                    // Unmapped writes dropped
      endcase
    end

    // Reads return stored values; soft reset and unmapped read zero
    if (reg_rd_en) begin
      unique case (reg_addr)
        limp_cfg_pkg::ADDR_MAIN_TIMER: st_d.rdata = st_q.main_timer;
        limp_cfg_pkg::ADDR_ENABLE_A:   st_d.rdata = st_q.enable_a;
        limp_cfg_pkg::ADDR_ENABLE_B:   st_d.rdata = st_q.enable_b;
        limp_cfg_pkg::ADDR_LATCH:      st_d.rdata = st_q.latch;
        limp_cfg_pkg::ADDR_OV_THRESH:  st_d.rdata = st_q.ov_thresh;
        limp_cfg_pkg::ADDR_TRIM:       st_d.rdata = st_q.trim;
        limp_cfg_pkg::ADDR_SOFT_RESET: st_d.rdata = limp_cfg_pkg::READ_ZERO;
        default:                       st_d.rdata = limp_cfg_pkg::READ_ZERO;
      endcase
    end

    // Fault flag follows qualified faults and timer expiry
    st_d.fault_oe = ch_fault_any | (ch_expired & {2{limp_home_pin}});

    // Force-off works in any mode; timer only under limp home; latch sets only under it but holds after the pin drops
    for (int c = 0; c < 2; c++) begin
      st_d.chan_off[c] =
        st_q.trim[limp_cfg_pkg::FIELD_STRIDE*c + limp_cfg_pkg::POS_FORCE_OFF]
        | ch_latched_off[c]
        | (ch_expired[c] & limp_home_pin);
      st_d.trim_out[limp_cfg_pkg::TRIM_W*c +: limp_cfg_pkg::TRIM_W] =
        st_q.trim[limp_cfg_pkg::FIELD_STRIDE*c + limp_cfg_pkg::POS_TRIM +: limp_cfg_pkg::TRIM_W];
      st_d.ov_out[limp_cfg_pkg::OV_CODE_W*c +: limp_cfg_pkg::OV_CODE_W] = ch_ov_code[c];
    end
  end

  // Power-on reset is the only path that restores the persistent bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q            <= '0;
      st_q.main_timer <= limp_cfg_pkg::RST_MAIN_TIMER;
      st_q.enable_a   <= limp_cfg_pkg::RST_ENABLE_A;
      st_q.enable_b   <= limp_cfg_pkg::RST_ENABLE_B;
      st_q.latch      <= limp_cfg_pkg::RST_LATCH;
      st_q.ov_thresh  <= limp_cfg_pkg::RST_OV_THRESH;
      st_q.trim       <= limp_cfg_pkg::RST_TRIM;
      st_q.pc_bit     <= limp_cfg_pkg::PC_POWER_ON;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign reg_rdata              = st_q.rdata;
  assign reg_rd_valid           = st_q.rd_valid;
  assign persistent_config_bit  = st_q.pc_bit;
  assign fault_pin_oe           = st_q.fault_oe;
  assign channel_off            = st_q.chan_off;
  assign ov_threshold_code      = st_q.ov_out;
  assign sense_offset_trim_bits = st_q.trim_out;

endmodule : limp_home_fault_config_regs

// [tb/limp_home_fault_config_regs_properties.sv]
// Checker: register port and fault pin relations of the limp bank
module limp_cfg_checker (
  input wire logic       clk,                   // Clock
  input wire logic       rst_n,                 // Reset
  input wire logic       reg_rd_en,             // Read strobe
  input wire logic [7:0] reg_addr,              // Address
  input wire logic [7:0] reg_rdata,             // Read data
  input wire logic       reg_rd_valid,          // Read valid
  input wire logic       persistent_config_wr,  // Persistent strobe
  input wire logic       persistent_config_bit, // Persistent bit
  input wire logic       limp_home_pin,         // Limp pin
  input wire logic       dual_phase_select,     // Dual phase
  input wire logic [5:0] fault_event_ch1,       // Faults ch1
  input wire logic [5:0] fault_event_ch2,       // Faults ch2
  input wire logic [1:0] fault_pin_oe,          // Fault pins
  input wire logic [5:0] ov_threshold_code      // OV codes
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rd_valid_pulse: // Read answered one cycle later
    assert property (reg_rd_en |=> reg_rd_valid) else $error("read not answered");
  a_rd_no_spurious: // No answer without a request
    assert property (!reg_rd_en |=> !reg_rd_valid) else $error("spurious read valid");
  a_soft_reset_zero:
    assert property (reg_rd_en && reg_addr == 8'h26 |=> reg_rdata == 8'h00)
      else $error("command register read not zero");
  a_reserved_bits_zero:
    assert property (reg_rd_en && reg_addr == 8'h22 |=> reg_rdata[7:6] == 2'b00)
      else $error("reserved enable bits read set");
  a_dual_ov_copy:
    assert property (dual_phase_select |=> ov_threshold_code[5:3] == ov_threshold_code[2:0])
      else $error("channel 2 code not copied in dual phase");
  a_persist_hold:
    assert property (!persistent_config_wr |=> $stable(persistent_config_bit))
      else $error("persistent bit changed without strobe");
  a_oe_cause_one:
    assert property ($rose(fault_pin_oe[0]) |-> $past(limp_home_pin)
      && ($past(fault_event_ch1 != 6'h00) || $past(dual_phase_select)))
      else $error("fault pin 1 without qualified fault");
  a_oe_cause_two:
    assert property ($rose(fault_pin_oe[1]) |-> $past(limp_home_pin)
      && ($past(fault_event_ch2 != 6'h00) || $past(dual_phase_select)))
      else $error("fault pin 2 without qualified fault");
endmodule : limp_cfg_checker

bind limp_home_fault_config_regs limp_cfg_checker chk_u (
  .clk(clk), .rst_n(rst_n), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
  .persistent_config_wr(persistent_config_wr),
  .persistent_config_bit(persistent_config_bit), .limp_home_pin(limp_home_pin),
  .dual_phase_select(dual_phase_select), .fault_event_ch1(fault_event_ch1),
  .fault_event_ch2(fault_event_ch2), .fault_pin_oe(fault_pin_oe),
  .ov_threshold_code(ov_threshold_code));

// [tb/host_bus_model.sv]
// Host model: register strobe port and channel enable rewrites
module host_bus_model (
  input  wire logic       clk,      // Clock
  output logic            wr_en,    // Write strobe
  output logic            rd_en,    // Read strobe
  output logic      [7:0] addr,     // Address
  output logic      [7:0] wdata,    // Write data
  output logic      [1:0] restart,  // Enable rewrite pulse
  input  wire logic [7:0] rdata,    // Read data
  input  wire logic       rd_valid  // Read valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Bus tasks
  // ****************
  initial begin
    {wr_en, rd_en, addr, wdata, restart} = '0;
  end
  // Idle bus shows the inverse so stale values never look valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr_en, addr, wdata} = {1'b1, a, d};
    @(negedge clk);
    {wr_en, addr, wdata} = {1'b0, ~a, ~d};
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    {rd_en, addr} = {1'b1, a};
    @(negedge clk);
    {rd_en, addr} = {1'b0, ~a};
    d = (rd_valid === 1'b1) ? rdata : 8'hxx;
  endtask : read_reg
  task automatic restart_ch(input int ch);
    @(negedge clk);
    restart[ch] = 1'b1;
    @(negedge clk);
    restart = 2'b00;
  endtask : restart_ch
endmodule : host_bus_model

// [tb/tb_limp_home_fault_config_regs.sv]
// Testbench: register map, fault timer, latching and soft reset
module tb_limp_home_fault_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h want %h", $time, g, e); end end
  // ****************
  // Signals and instances
  // ****************
  logic       clk, rst_n, pc_wr, pc_wd, limp, dual, ck_on, cv;
  logic [1:0] chclk, ss;
  logic [5:0] ev1, ev2;
  wire        wr_en, rd_en, rd_valid, pc_bit;
  wire  [7:0] addr, wdata, rdata;
  wire  [1:0] restart, oe, off;
  wire  [5:0] ovc, trim;
  logic [7:0] d;
  int         error_cnt, comparisons, i;
  localparam logic [7:0] DEF [8] = '{8'h99, 8'h3c, 8'h0f, 8'h00, 8'h22, 8'h00, 8'h00, 8'h00};
  host_bus_model host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .restart(restart), .rdata(rdata), .rd_valid(rd_valid));
  limp_home_fault_config_regs dut_u (.clk(clk), .rst_n(rst_n), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rd_valid(rd_valid), .persistent_config_wr(pc_wr),
    .persistent_config_wdata(pc_wd), .persistent_config_bit(pc_bit),
    .limp_home_pin(limp), .dual_phase_select(dual), .cv_mode(cv),
    .channel_clock(chclk), .soft_start_active(ss), .channel_restart(restart),
    .fault_event_ch1(ev1), .fault_event_ch2(ev2), .fault_pin_oe(oe),
    .channel_off(off), .ov_threshold_code(ovc), .sense_offset_trim_bits(trim));
  // Clock, and channel clock that stands still when off
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) chclk <= ck_on ? ~chclk : 2'b00;
  // ****************
  // Tasks
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic defaults;
    for (i = 0; i < 8; i++) begin
      host_u.read_reg(8'h20 + 8'(i), d);
      `CHK(d, DEF[i])
    end
  endtask : defaults
  task automatic results;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // Watchdog sized well past the longest timer run
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
  // ****************
  // Sequence
  // ****************
  initial begin
    {rst_n, pc_wr, pc_wd, limp, dual, ck_on, cv, ss, chclk, ev1, ev2} = '0;
    {error_cnt, comparisons} = '0;
    cyc(5);
    rst_n = 1'b1;
    defaults();
    host_u.write_reg(8'h22, 8'hff);
    host_u.read_reg(8'h22, d);
    `CHK(d, 8'h3f)
    host_u.write_reg(8'h24, 8'hff);
    host_u.read_reg(8'h24, d);
    `CHK(d, 8'h77)
    `CHK(ovc, 6'h3f)
    host_u.write_reg(8'h24, 8'h35);
    cyc(2);
    `CHK(ovc, 6'h1d)
    dual = 1'b1;
    cyc(2);
    `CHK(ovc, 6'h2d)
    // Timed OV fault in dual phase, code 1 gives 1000 ticks, one tick per two cycles
    host_u.write_reg(8'h20, 8'h91);
    {limp, ev1, ev2, ck_on} = {1'b1, 6'h02, 6'h03, 1'b1};
    cyc(2);
    `CHK(oe[0], 1'b1)
    `CHK(oe[1], 1'b0)
    cyc(1990);
    `CHK(off[0], 1'b0)
    for (i = 0; i < 40 && off[0] !== 1'b1; i++) cyc(1);
    `CHK(off[0], 1'b1)
    `CHK(off[1], 1'b1)
    {ev1, ev2, ck_on, dual} = '0;
    host_u.write_reg(8'h20, 8'h90);
    {ev1, ck_on} = {6'h02, 1'b1};
    cyc(2100);
    `CHK(off[0], 1'b0)
    {ev1, ck_on} = '0;
    host_u.write_reg(8'h21, 8'h00);
    ev1 = 6'h07;
    cyc(3);
    `CHK(oe[0], 1'b0)
    host_u.write_reg(8'h21, 8'h3c);
    limp = 1'b0;
    cyc(3);
    `CHK(oe[0], 1'b0)
    limp = 1'b1;
    cyc(3);
    `CHK(oe[0], 1'b1)
    ev1 = 6'h00;
    // Soft start with ramp enable low: UV masked, CURRENT_LIMIT too in CV mode
    host_u.write_reg(8'h22, 8'h04);
    host_u.write_reg(8'h21, 8'h15);
    {ss, cv, ev1} = {2'b01, 1'b1, 6'h11};
    cyc(3);
    `CHK(oe[0], 1'b0)
    {cv, ev1} = {1'b0, 6'h01};
    cyc(3);
    `CHK(oe[0], 1'b0)
    ev1 = 6'h11;
    cyc(3);
    `CHK(oe[0], 1'b1)
    {cv, ev1} = {1'b1, 6'h01};
    host_u.write_reg(8'h21, 8'h55);
    cyc(2);
    `CHK(oe[0], 1'b1)
    {ss, cv, ev1} = '0;
    cyc(2);
    ev1 = 6'h04;
    cyc(3);
    `CHK(oe[0], 1'b1)
    ev1 = 6'h00;
    // Latched OV: a short fault keeps the channel off until restart
    host_u.write_reg(8'h23, 8'h04);
    ev1 = 6'h02;
    cyc(1);
    ev1 = 6'h00;
    cyc(4);
    `CHK(off[0], 1'b1)
    host_u.restart_ch(0);
    cyc(2);
    `CHK(off[0], 1'b0)
    host_u.write_reg(8'h25, 8'he1);
    cyc(2);
    `CHK(off[0], 1'b1)
    `CHK(trim, 6'h38)
    host_u.write_reg(8'h26, 8'h12);
    host_u.read_reg(8'h25, d);
    `CHK(d, 8'he1)
    {pc_wr, pc_wd} = 2'b10;
    cyc(1);
    pc_wr = 1'b0;
    host_u.write_reg(8'h26, 8'hc3);
    defaults();
    `CHK(pc_bit, 1'b0)
    `CHK(off[0], 1'b0)
    results();
  end
endmodule : tb_limp_home_fault_config_regs
